// ==== design/supervisor_reset_config.sv ====
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
// supervisor configuration bank, reset-pin control and watchdog timing
module supervisor_reset_config #(
  parameter int unsigned HOLD_8MS_CYC  = supervisor_pkg::HOLD_8MS_CYC,
  parameter int unsigned HOLD_16MS_CYC = supervisor_pkg::HOLD_16MS_CYC,
  parameter int unsigned HOLD_32MS_CYC = supervisor_pkg::HOLD_32MS_CYC
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    arst_n_i,
  // avalon-mm slave
  input  wire supervisor_pkg::av_req_t av_req_i,
  output logic [31:0]                  av_readdata_o,
  output logic                         av_waitrequest_o,
  // factory image, sampled once after reset release
  input  wire supervisor_pkg::cfg_t    otp_image_i,
  // fault sources from the analog side
  input  wire supervisor_pkg::fault_t  fault_i,
  // watchdog pins
  input  wire logic                    refresh_pin_i,
  input  wire logic                    wd_disable_i,
  // open-drain reset pin
  output logic                         reset_pin_o,
  output logic                         reset_pin_oe_o,
  // live configuration to the comparators
  output supervisor_pkg::cfg_t         cfg_o,
  // interrupt
  output logic                         irq_o
);
  localparam int HW = 24;  // hold counter width
  localparam int PW = 17;  // prescaler width, 64 x 2000 cycles
  localparam int CW = 12;  // window counter width, 3600 ticks max

  // refuse hold counts the counter cannot hold
  if (HOLD_8MS_CYC < 1 || HOLD_16MS_CYC < 1 || HOLD_32MS_CYC < 1 ||
      HOLD_32MS_CYC >= (1 << HW) || HOLD_16MS_CYC >= (1 << HW) ||
      HOLD_8MS_CYC >= (1 << HW)) begin : g_bad_hold
    $error("hold cycle parameter out of range");
  end

  // all state of the block
  typedef struct packed {
    supervisor_pkg::cfg_t      cfg;
    logic                      loaded;   // factory image taken
    logic                      wait_rq;  // bus waitrequest
    logic [31:0]               rdata;
    logic [3:0]                status;   // sticky events
    logic [3:0]                mask;
    logic                      irq;
    logic                      rst_act;  // reset pin pulled low
    supervisor_pkg::wd_state_t wd;
    logic [CW-1:0]             wd_cnt;   // ticks left in window
    logic                      wd_fault; // window violation
  } st_t;
  st_t r_r;
  st_t r_nxt;

  // synchronised pins
  logic [10:0] syn_lvl;   // {disable, refresh, parity, selftest, ch7..ch1}
  logic [10:0] syn_rise;
  sync_edge #(
    .W (11)
  ) u_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .async_i  ({wd_disable_i, refresh_pin_i, fault_i}),
    .level_o  (syn_lvl),
    .rise_o   (syn_rise)
  );
  logic       wd_dis;    // watchdog disabled by pin
  logic       refresh;   // refresh attempt pulse
  logic [6:0] ch_flt;    // channel over or under voltage
  assign wd_dis  = syn_lvl[10];
  assign refresh = syn_rise[9];  // [RULE12]
  assign ch_flt  = syn_lvl[6:0];

  // fault mapping
  logic [7:0] map;        // fault-to-reset map
  logic       ch_hit;
  logic       par_hit;
  logic       st_hit;
  logic       fault_any;
  assign map     = r_r.cfg[supervisor_pkg::SLOT_MAP];
  assign ch_hit  = |(ch_flt & map[6:0]);  // [RULE7]
  assign par_hit = syn_lvl[8] & map[supervisor_pkg::PARITY_MAP_BIT];  // [RULE6]
  assign st_hit  = syn_lvl[7] &
    r_r.cfg[supervisor_pkg::SLOT_GENERAL][supervisor_pkg::SELFTEST_MAP_BIT];  // [RULE5]
  // unloaded image counts as a fault so nothing acts on stale values
  assign fault_any = !r_r.loaded | ch_hit | par_hit | st_hit | r_r.wd_fault;  // [RULE2] [RULE15]

  // hold time selection
  logic [1:0]    rel_sel;
  logic [HW-1:0] hold_val;
  logic          hold_zero;
  assign rel_sel = r_r.cfg[supervisor_pkg::SLOT_RESET_OUTPUT_CONTROL][supervisor_pkg::RELSEL_LSB +: 2];
  always_comb begin
    // one code per selectable hold time
    unique case (rel_sel)
      2'b00: hold_val = HW'(supervisor_pkg::HOLD_6US_CYC);  // [RULE3]
      2'b01: hold_val = HW'(HOLD_8MS_CYC);
      2'b10: hold_val = HW'(HOLD_16MS_CYC);
      2'b11: hold_val = HW'(HOLD_32MS_CYC);
    endcase
  end
  // reloaded while any fault stands, so a new fault restarts the hold
  cycle_timer #(
    .W (HW)
  ) u_hold (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .load_i   (fault_any),  // [RULE16]
    .value_i  (hold_val),
    .zero_o   (hold_zero)
  );

  // watchdog tick prescaler
  logic [5:0]    tick_div;
  logic [PW-1:0] tick_reload;
  logic          presc_zero;
  logic          tick;
  logic          presc_load;
  assign tick_div    = r_r.cfg[supervisor_pkg::SLOT_TICKDIV][supervisor_pkg::DIV_LSB +: 6];
  assign tick_reload = PW'((tick_div + 7'd1) * supervisor_pkg::TICK_BASE_CYC - 1);
  assign tick        = presc_zero && (r_r.wd != supervisor_pkg::WD_IDLE);
  assign presc_load  = presc_zero || (r_r.wd == supervisor_pkg::WD_IDLE);
  cycle_timer #(
    .W (PW)
  ) u_presc (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .load_i   (presc_load),
    .value_i  (tick_reload),
    .zero_o   (presc_zero)
  );

  // window lengths in ticks
  logic [3:0]    shut_cnt;
  logic [3:0]    accept_cnt;
  logic [2:0]    first_mult;
  logic [CW-1:0] shut_len;
  logic [CW-1:0] accept_len;
  logic [CW-1:0] first_len;
  logic          expire;
  assign shut_cnt   = r_r.cfg[supervisor_pkg::SLOT_WINDOW][supervisor_pkg::SHUT_LSB +: 4];
  assign accept_cnt = r_r.cfg[supervisor_pkg::SLOT_WINDOW][supervisor_pkg::ACCEPT_LSB +: 4];
  assign first_mult = r_r.cfg[supervisor_pkg::SLOT_FIRST][supervisor_pkg::MULT_LSB +: 3];
  assign shut_len   = CW'(shut_cnt * supervisor_pkg::WINDOW_UNIT);    // [RULE11]
  assign accept_len = CW'(accept_cnt * supervisor_pkg::WINDOW_UNIT);  // [RULE11]
  assign first_len  = CW'((shut_len + accept_len) * (1 + 2 * first_mult));  // [RULE1]
  // window ends on the tick that empties it
  assign expire = tick && (r_r.wd_cnt <= CW'(1));

  // bus decode
  logic [5:0] idx;
  logic       req;
  assign idx = av_req_i.address[7:2];
  assign req = av_req_i.read | av_req_i.write;

  // next state
  always_comb begin
    int         i;
    logic [7:0] rd;
    logic       hit;
    logic       early;
    logic       late;
    logic [3:0] ev;
    logic [3:0] clr;
    i     = 0;
    rd    = 8'h00;
    hit   = 1'b0;
    early = 1'b0;
    late  = 1'b0;
    ev    = 4'h0;
    clr   = 4'h0;
    r_nxt = r_r;

    // factory image once, right after reset release
    if (!r_r.loaded) begin
      for (i = 0; i < supervisor_pkg::NREG; i++) begin
        r_nxt.cfg[i] = otp_image_i[i] & supervisor_pkg::REG_WMASK[i];  // [RULE15]
      end
      r_nxt.loaded = 1'b1;
      ev[supervisor_pkg::EV_LOAD] = 1'b1;
    end

    // read mux, unmapped reads give zero
    for (i = 0; i < supervisor_pkg::NREG; i++) begin
      if (idx == supervisor_pkg::REG_IDX[i]) begin
        rd  = r_r.cfg[i];  // [RULE10]
        hit = 1'b1;
      end
    end
    if (idx == supervisor_pkg::IDX_EVENT_STATUS) begin
      rd = {4'h0, r_r.status};
    end else if (idx == supervisor_pkg::IDX_EVENT_MASK) begin
      rd = {4'h0, r_r.mask};
    end else if (idx == supervisor_pkg::IDX_MONITOR) begin
      rd = {r_r.wd_fault, r_r.loaded, r_r.wd, hold_zero, wd_dis, fault_any, r_r.rst_act};
    end

    // one wait cycle, then waitrequest low for one cycle
    if (r_r.wait_rq && req) begin
      r_nxt.wait_rq = 1'b0;
      r_nxt.rdata   = av_req_i.read ? {24'h0000_00, rd} : 32'h0000_0000;
    end else begin
      r_nxt.wait_rq = 1'b1;
    end

    // writes land on the edge that sees waitrequest low
    if (!r_r.wait_rq && av_req_i.write && av_req_i.byteenable[0] && r_r.loaded) begin
      for (i = 0; i < supervisor_pkg::NREG; i++) begin
        if (idx == supervisor_pkg::REG_IDX[i]) begin
          r_nxt.cfg[i] = av_req_i.writedata[7:0] & supervisor_pkg::REG_WMASK[i];  // [RULE10]
        end
      end
      if (idx == supervisor_pkg::IDX_EVENT_STATUS) begin
        clr = av_req_i.writedata[3:0];
      end
      if (idx == supervisor_pkg::IDX_EVENT_MASK) begin
        r_nxt.mask = av_req_i.writedata[3:0];
      end
    end

    // reset pin: asserted with any fault and through the hold
    r_nxt.rst_act = fault_any | !hold_zero;  // [RULE2] [RULE3]

    // watchdog windows
    if (tick && r_r.wd_cnt != '0) begin
      r_nxt.wd_cnt = r_r.wd_cnt - 1'b1;
    end
    unique case (r_r.wd)
      supervisor_pkg::WD_IDLE: begin
        // starts open and stretched, no closed part
        if (!r_r.rst_act && r_r.loaded && !wd_dis) begin
          r_nxt.wd     = supervisor_pkg::WD_FIRST;  // [RULE13]
          r_nxt.wd_cnt = first_len;  // [RULE1]
        end
      end
      supervisor_pkg::WD_FIRST: begin
        if (refresh) begin
          r_nxt.wd     = supervisor_pkg::WD_CLOSED;  // [RULE13]
          r_nxt.wd_cnt = shut_len;
        end else if (expire) begin
          late = 1'b1;
        end
      end
      supervisor_pkg::WD_CLOSED: begin
        if (refresh) begin
          early = 1'b1;  // [RULE12]
        end else if (expire || shut_len == '0) begin
          r_nxt.wd     = supervisor_pkg::WD_OPEN;
          r_nxt.wd_cnt = accept_len;
        end
      end
      supervisor_pkg::WD_OPEN: begin
        // a good refresh cuts the open window short
        if (refresh) begin
          r_nxt.wd     = supervisor_pkg::WD_CLOSED;
          r_nxt.wd_cnt = shut_len;
        end else if (expire) begin
          late = 1'b1;
        end
      end
    endcase
    r_nxt.wd_fault = early | late;
    // watchdog sleeps while reset is low or the pin disables it
    if (early || late || r_r.rst_act || wd_dis) begin
      r_nxt.wd = supervisor_pkg::WD_IDLE;
    end

    // sticky events, a new event beats a clear
    ev[supervisor_pkg::EV_RESET] = r_nxt.rst_act & !r_r.rst_act & r_r.loaded;
    ev[supervisor_pkg::EV_EARLY] = early;
    ev[supervisor_pkg::EV_LATE]  = late;
    r_nxt.status = (r_r.status & ~clr) | ev;
    r_nxt.irq    = |(r_nxt.status & r_nxt.mask);
  end

  // state register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_r         <= '0;
      r_r.wait_rq <= 1'b1;
      r_r.rst_act <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from state flops, reset_pin_o tied low
  assign av_readdata_o    = r_r.rdata;
  assign av_waitrequest_o = r_r.wait_rq;
  assign reset_pin_o      = 1'b0;         // [RULE4]
  assign reset_pin_oe_o   = r_r.rst_act;  // [RULE4]
  assign cfg_o            = r_r.cfg;      // [RULE8] [RULE9] [RULE14]
  assign irq_o            = r_r.irq;
endmodule

// ==== design/supervisor_pkg.sv ====
// What this block does
// RULE1: first window is (open+closed) times (1+2*multiplier)
// RULE2: mapped active fault pulls reset low
// RULE3: reset held 6us/8ms/16ms/32ms after faults clear
// RULE4: reset pin only pulled low or released
// RULE5: self-test failures map to reset when enabled
// RULE6: parity failures map to reset when enabled
// RULE7: map bits 0-6 enable channels 1-7
// RULE8: channels 1-4 nominal 500mV plus 12.5mV/step
// RULE9: channel 5 nominal 500mV plus 20mV/step
// RULE10: every configuration field is readable and writable
// RULE11: window lengths are tick times 8 times count
// RULE12: rising edge on refresh pin is refresh attempt
// RULE13: first watchdog cycle has no closed window
// RULE14: limits 102.5%+0.5%/step and 97.5%-0.5%/step
// RULE15: factory image loaded before mapping and watchdog act
// RULE16: fault during hold restarts hold after clearing
package supervisor_pkg;
  // clock
  localparam int CLK_PERIOD_NS = 100;
  // configuration slots: one byte each
  localparam int NREG = 20;
  typedef logic [NREG-1:0][7:0] cfg_t;
  // register indices, byte address is four times the index
  localparam logic [NREG-1:0][5:0] REG_IDX = {
    6'h2c, 6'h29, 6'h28, 6'h27, 6'h15, 6'h14, 6'h13, 6'h12, 6'h11, 6'h10,
    6'h0f, 6'h0e, 6'h0d, 6'h0c, 6'h0b, 6'h0a, 6'h09, 6'h08, 6'h04, 6'h01};
  // writable bits per slot, the rest read zero
  localparam logic [NREG-1:0][7:0] REG_WMASK = {
    8'h07, 8'h07, 8'hff, 8'h3f, {15{8'hff}}, 8'h02};
  // block's own registers
  localparam logic [5:0] IDX_EVENT_STATUS = 6'h30;
  localparam logic [5:0] IDX_EVENT_MASK   = 6'h31;
  localparam logic [5:0] IDX_MONITOR      = 6'h32;
  // slot numbers
  localparam int SLOT_GENERAL = 0;
  localparam int SLOT_MAP     = 1;
  localparam int SLOT_NOM1    = 2;   // channels 1..5 in slots 2..6
  localparam int SLOT_LIMIT1  = 11;  // channels 1..5 in slots 11..15
  localparam int SLOT_TICKDIV = 16;
  localparam int SLOT_WINDOW  = 17;
  localparam int SLOT_FIRST   = 18;
  localparam int SLOT_RESET_OUTPUT_CONTROL = 19;
  // field positions
  localparam int SELFTEST_MAP_BIT = 1;
  localparam int PARITY_MAP_BIT   = 7;
  localparam int SHUT_LSB         = 4;
  localparam int ACCEPT_LSB       = 0;
  localparam int MULT_LSB         = 0;
  localparam int DIV_LSB          = 0;
  localparam int RELSEL_LSB       = 0;
  // analog scaling of stored codes, in microvolts and per-mille
  localparam int NOM_BASE_UV      = 500000;  // [RULE8] [RULE9]
  localparam int NOM_STEP_LO_UV   = 12500;   // [RULE8]
  localparam int NOM_STEP_CH5_UV  = 20000;   // [RULE9]
  localparam int OV_BASE_PERMILLE = 1025;    // [RULE14]
  localparam int UV_BASE_PERMILLE = 975;     // [RULE14]
  localparam int LIMIT_STEP_PERMILLE = 5;    // [RULE14]
  // timing
  localparam int HOLD_6US_NS  = 6000;
  localparam int HOLD_8MS_NS  = 8000000;
  localparam int HOLD_16MS_NS = 16000000;
  localparam int HOLD_32MS_NS = 32000000;
  localparam int HOLD_6US_CYC  = HOLD_6US_NS / CLK_PERIOD_NS;
  localparam int HOLD_8MS_CYC  = HOLD_8MS_NS / CLK_PERIOD_NS;
  localparam int HOLD_16MS_CYC = HOLD_16MS_NS / CLK_PERIOD_NS;
  localparam int HOLD_32MS_CYC = HOLD_32MS_NS / CLK_PERIOD_NS;
  localparam int TICK_BASE_NS  = 200000;
  localparam int TICK_BASE_CYC = TICK_BASE_NS / CLK_PERIOD_NS;
  localparam int WINDOW_UNIT   = 8;
  // event bits
  localparam int EV_RESET = 0;
  localparam int EV_EARLY = 1;
  localparam int EV_LATE  = 2;
  localparam int EV_LOAD  = 3;
  // watchdog states
  typedef enum logic [1:0] {
    WD_IDLE   = 2'b00,
    WD_FIRST  = 2'b01,
    WD_CLOSED = 2'b10,
    WD_OPEN   = 2'b11
  } wd_state_t;
  // avalon request
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } av_req_t;
  // fault sources
  typedef struct packed {
    logic       parity;
    logic       selftest;
    logic [6:0] channel;
  } fault_t;
endpackage

// ==== design/sync_edge.sv ====
`timescale 1ns/1ps
// two-stage synchroniser with rising-edge detect on the settled copy
module sync_edge #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  // asynchronous inputs
  input  wire logic [W-1:0] async_i,
  // synchronised level and edge
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o
);
  typedef struct packed {
    logic [W-1:0] s1;  // metastable stage, read only by s2
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } st_t;
  st_t r_r;
  st_t r_nxt;
  // shift chain
  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = async_i;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end
  assign level_o = r_r.s2;
  assign rise_o  = r_r.s2 & ~r_r.s3;
endmodule

// ==== design/cycle_timer.sv ====
`timescale 1ns/1ps
// loadable down counter, stops at zero
module cycle_timer #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  // control
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  // status
  output logic              zero_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } st_t;
  st_t r_r;
  st_t r_nxt;
  // load wins over counting
  always_comb begin
    r_nxt = r_r;
    if (load_i) begin
      r_nxt.cnt = value_i;
    end else if (r_r.cnt != '0) begin
      r_nxt.cnt = r_r.cnt - 1'b1;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end
  assign zero_o = (r_r.cnt == '0);
endmodule

// ==== sim/supervisor_asserts.sv ====
`timescale 1ns/1ps
// port-level checks of bus answers, fault mapping and the reset hold time
module supervisor_asserts #(
  parameter int unsigned HOLD_8MS_CYC  = 200,
  parameter int unsigned HOLD_16MS_CYC = 400,
  parameter int unsigned HOLD_32MS_CYC = 800
) (
  // clock and reset
  input wire logic                    clk_i,
  input wire logic                    arst_n_i,
  // register bus
  input wire supervisor_pkg::av_req_t av_req_i,
  input wire logic [31:0]             av_readdata_o,
  input wire logic                    av_waitrequest_o,
  // faults, pin and configuration
  input wire supervisor_pkg::fault_t  fault_i,
  input wire logic                    reset_pin_o,
  input wire logic                    reset_pin_oe_o,
  input wire supervisor_pkg::cfg_t    cfg_o
);
  localparam int GEN = supervisor_pkg::SLOT_GENERAL;
  localparam int MAP = supervisor_pkg::SLOT_MAP;
  localparam int WIN = supervisor_pkg::SLOT_WINDOW;
  localparam int RST = supervisor_pkg::SLOT_RESET_OUTPUT_CONTROL;
  logic        mapped;    // some enabled source is active right now
  logic [15:0] quiet_r;   // cycles since the last mapped fault, saturating
  logic [7:0]  wdata;     // byte lane that a write carries
  int unsigned hold_min;  // shortest legal hold for the current select
  assign wdata = av_req_i.writedata[7:0];
  assign mapped = (|(fault_i.channel & cfg_o[MAP][6:0])) | (fault_i.parity & cfg_o[MAP][7])
                | (fault_i.selftest & cfg_o[GEN][1]);
  // raw inputs are counted, so the pin may only release later than this
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      quiet_r <= 16'h0000;
    end else if (mapped) begin
      quiet_r <= 16'h0000;
    end else if (quiet_r != 16'hffff) begin
      quiet_r <= quiet_r + 16'h0001;
    end
  end
  // hold figure per select code
  always_comb begin
    case (cfg_o[RST][1:0])
      2'd0:    hold_min = supervisor_pkg::HOLD_6US_CYC;
      2'd1:    hold_min = HOLD_8MS_CYC;
      2'd2:    hold_min = HOLD_16MS_CYC;
      default: hold_min = HOLD_32MS_CYC;
    endcase
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_taken;
    (av_req_i.read || av_req_i.write) && av_waitrequest_o;
  endsequence
  sequence s_answer;
    !av_waitrequest_o ##1 av_waitrequest_o;
  endsequence
  chk_bus_answer: assert property (s_taken |=> s_answer)
    else $error("bus request not answered for exactly one cycle");
  chk_read_upper: assert property (!av_waitrequest_o |-> av_readdata_o[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  chk_read_map: assert property (av_req_i.read && !av_waitrequest_o && av_req_i.address == 8'h10 |-> av_readdata_o[7:0] == cfg_o[MAP])
    else $error("map read differs from live map");
  chk_write_lands: assert property (av_req_i.write && av_req_i.byteenable[0] && !av_waitrequest_o && av_req_i.address == 8'ha0 |=> cfg_o[WIN] == $past(wdata))
    else $error("window write did not land");
  chk_pin_low_only: assert property (reset_pin_o == 1'b0)
    else $error("reset pin driven high");
  chk_chan_map: assert property ((|(fault_i.channel & cfg_o[MAP][6:0]))[*5] |-> reset_pin_oe_o)
    else $error("mapped channel fault did not pull reset");
  chk_parity_map: assert property ((fault_i.parity && cfg_o[MAP][7])[*5] |-> reset_pin_oe_o)
    else $error("mapped parity fault did not pull reset");
  chk_selftest_map: assert property ((fault_i.selftest && cfg_o[GEN][1])[*5] |-> reset_pin_oe_o)
    else $error("mapped self-test fault did not pull reset");
  chk_hold_time: assert property ($fell(reset_pin_oe_o) |-> 32'(quiet_r) >= hold_min)
    else $error("reset released before hold time");
endmodule

// ==== sim/soc_model.sv ====
`timescale 1ns/1ps
// processor side: sees the pulled-up reset line and pulses the refresh pin
module soc_model (
  // clock
  input  wire logic clk_i,
  // open-drain reset from the supervisor
  input  wire logic reset_pin_i,
  input  wire logic reset_pin_oe_i,
  // refresh request from the bench
  input  wire logic kick_i,
  // what the processor sees and drives
  output logic      reset_line_o,
  output logic      refresh_pin_o
);
  logic [2:0] width_r = 3'd0;  // cycles left of the refresh pulse
  // a released line floats to the pull-up level, only low is ever driven
  assign reset_line_o = reset_pin_oe_i ? reset_pin_i : 1'b1;
  // one clean rising edge per request while the reset line is high, long enough for a two-flop synchroniser
  initial refresh_pin_o = 1'b0;
  always @(posedge clk_i) begin
    if (kick_i && reset_line_o) begin
      width_r <= 3'd4;
    end else if (width_r != 3'd0) begin
      width_r <= width_r - 3'd1;
    end
    refresh_pin_o <= (width_r != 3'd0);
  end
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
// drives registers, faults and refreshes; judges the reset line timing
module testbench;
  localparam int H8 = 200;  // shortened hold counts keep the run brief
  localparam int H16 = 400;
  localparam int H32 = 800;
  logic                    clk_i = 1'b0;
  logic                    arst_n_i = 1'b0;
  supervisor_pkg::av_req_t av_req = '0;
  supervisor_pkg::cfg_t    otp = '0;
  supervisor_pkg::fault_t  fault = '0;
  supervisor_pkg::cfg_t    cfg_w;
  logic [31:0]             rdata;
  logic                    wait_w, pin_w, oe_w, irq_w, line_w, refresh_w;
  logic                    wd_dis = 1'b1;
  logic                    kick = 1'b0;
  int                      bad_count = 0, compares = 0, cycles = 0, n;
  int                      holds[4] = '{supervisor_pkg::HOLD_6US_CYC, H8, H16, H32};
  always #50 clk_i = ~clk_i;
  supervisor_reset_config #(.HOLD_8MS_CYC(H8), .HOLD_16MS_CYC(H16), .HOLD_32MS_CYC(H32))
  u_supervisor_reset_config (.clk_i(clk_i), .arst_n_i(arst_n_i), .av_req_i(av_req),
    .av_readdata_o(rdata), .av_waitrequest_o(wait_w), .otp_image_i(otp), .fault_i(fault),
    .refresh_pin_i(refresh_w), .wd_disable_i(wd_dis), .reset_pin_o(pin_w),
    .reset_pin_oe_o(oe_w), .cfg_o(cfg_w), .irq_o(irq_w));
  soc_model u_soc_model (.clk_i(clk_i), .reset_pin_i(pin_w), .reset_pin_oe_i(oe_w),
    .kick_i(kick), .reset_line_o(line_w), .refresh_pin_o(refresh_w));
  task automatic close_out;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int w;
    w = 0;
    av_req.read <= !wr;
    av_req.write <= wr;
    av_req.address <= a;
    av_req.byteenable <= 4'hf;
    av_req.writedata <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      w++;
    end while (wait_w !== 1'b0);
    check(w, 2);
    q = rdata[7:0];
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  // count cycles while the reset line stays at one level
  task automatic span(input logic lvl, input int lim, output int k);
    k = 0;
    while (line_w === lvl && k < lim) begin
      @(posedge clk_i);
      k++;
    end
  endtask
  // raise a fault source, expect the line to follow the mapping, then the hold
  task automatic pulse(input logic [8:0] src, input logic hit, input int hold);
    fault <= supervisor_pkg::fault_t'(src);
    tick(8);
    check(line_w, !hit);
    fault <= '0;
    if (hit) begin
      tick(hold - 10);
      check(line_w, 1'b0);
      tick(25);
      check(line_w, 1'b1);
    end
    tick(4);
  endtask
  task automatic t_regs;
    logic [7:0] q, m, a;
    for (int i = 0; i < supervisor_pkg::NREG; i++) begin
      m = supervisor_pkg::REG_WMASK[i];
      a = {supervisor_pkg::REG_IDX[i], 2'b00};
      bus(1'b0, a, 8'h00, q);
      check(q, otp[i] & m);
      wr(a, 8'ha5 ^ 8'(i));
      bus(1'b0, a, 8'h00, q);
      check(q, (8'ha5 ^ 8'(i)) & m);
      check(cfg_w[i], (8'ha5 ^ 8'(i)) & m);
    end
    wr(8'h08, 8'hff);
    bus(1'b0, 8'h08, 8'h00, q);
    check(q, 8'h00);
    $display("register test done");
  endtask
  task automatic t_hold;
    wr(8'h04, 8'h00);
    wr(8'h10, 8'h01);
    for (int s = 0; s < 4; s++) begin
      wr(8'hb0, 8'(s));
      pulse(9'h001, 1'b1, holds[s]);
    end
    wr(8'hb0, 8'h00);
    // a fault that returns mid-hold must restart the count
    fault <= 9'h001;
    tick(8);
    fault <= '0;
    tick(30);
    fault <= 9'h001;
    tick(3);
    fault <= '0;
    tick(50);
    check(line_w, 1'b0);
    tick(25);
    check(line_w, 1'b1);
    $display("hold test done");
  endtask
  task automatic t_map;
    logic [8:0] src;
    for (int k = 0; k < 9; k++) begin
      src = 9'h001 << k;
      wr(8'h04, {6'h00, src[7], 1'b0});
      wr(8'h10, {src[8], src[6:0]});
      pulse(src, 1'b1, holds[0]);
      wr(8'h04, {6'h00, !src[7], 1'b0});
      wr(8'h10, ~{src[8], src[6:0]});
      pulse(src, 1'b0, holds[0]);
    end
    $display("mapping test done");
  endtask
  task automatic t_irq;
    logic [7:0] q;
    bus(1'b0, 8'hc0, 8'h00, q);
    check(q & 8'h08, 8'h08);
    wr(8'hc0, 8'hff);
    wr(8'hc4, 8'h01);
    check(irq_w, 1'b0);
    pulse(9'h001, 1'b1, holds[0]);
    check(irq_w, 1'b1);
    wr(8'hc4, 8'h00);
    tick(2);
    check(irq_w, 1'b0);
    wr(8'hc4, 8'h01);
    tick(2);
    check(irq_w, 1'b1);
    wr(8'hc0, 8'h01);
    tick(2);
    check(irq_w, 1'b0);
    $display("interrupt test done");
  endtask
  // shut 1, accept 0, multiplier 1: the first window is three whole cycles
  task automatic t_wdog;
    int exp;
    exp = 8 * (1 + 0) * (1 + 2 * 1) * supervisor_pkg::TICK_BASE_CYC;
    wr(8'h9c, 8'h00);
    wr(8'ha0, 8'h10);
    wr(8'ha4, 8'h01);
    wd_dis <= 1'b0;
    fault <= 9'h001;
    tick(8);
    fault <= '0;
    span(1'b0, 200, n);
    span(1'b1, 60000, n);
    check(n >= exp && n <= exp + 2100, 1'b1);
    span(1'b0, 200, n);
    tick(1000);
    kick <= 1'b1;
    tick(1);
    kick <= 1'b0;
    span(1'b1, 20000, n);
    exp = 8 * 1 * supervisor_pkg::TICK_BASE_CYC;
    check(n >= exp && n <= exp + 2100, 1'b1);
    wd_dis <= 1'b1;
    span(1'b0, 200, n);
    $display("watchdog test done");
  endtask
  // hang guard, about three tenths above the expected run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    for (int i = 0; i < supervisor_pkg::NREG; i++) begin
      otp[i] = 8'h3c ^ {i[3:0], 4'h0};
    end
    tick(8);
    arst_n_i <= 1'b1;
    tick(2);
    span(1'b0, 200, n);
    t_regs();
    t_hold();
    t_map();
    t_irq();
    t_wdog();
    close_out();
  end
endmodule
bind supervisor_reset_config supervisor_asserts #(
  .HOLD_8MS_CYC (HOLD_8MS_CYC),
  .HOLD_16MS_CYC(HOLD_16MS_CYC),
  .HOLD_32MS_CYC(HOLD_32MS_CYC)
) u_supervisor_asserts (.clk_i(clk_i), .arst_n_i(arst_n_i), .av_req_i(av_req_i),
  .av_readdata_o(av_readdata_o), .av_waitrequest_o(av_waitrequest_o), .fault_i(fault_i),
  .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o), .cfg_o(cfg_o));
